// [core/motion_event_defs.svh]
`ifndef MOTION_EVENT_DEFS_SVH
`define MOTION_EVENT_DEFS_SVH

// Register indices; byte address is four times the index
`define MFE_IDX_STATUS 8'h12
`define MFE_IDX_CTRL 8'h20
`define MFE_IDX_OR_THR 8'h21
`define MFE_IDX_TAP_THR 8'h22
`define MFE_IDX_TAP_MAX_DURATION 8'h23
`define MFE_IDX_TAP_LAT 8'h24
`define MFE_IDX_TAP_WIN 8'h25
`define MFE_IDX_MASK 8'h26
`define MFE_IDX_FUSE_CHK 8'h27

// Status field positions
`define MFE_ST_FUSE 7
`define MFE_ST_INACTIVITY_FLAG 6
`define MFE_ST_ACT 5
`define MFE_ST_OR_STICKY 4
`define MFE_ST_OR_LIVE 3
`define MFE_ST_TRIPLE 2
`define MFE_ST_DOUBLE 1
`define MFE_ST_SINGLE 0

// Control field positions
`define MFE_CTRL_OR_DIS 0
`define MFE_CTRL_TRIG_SEL 1
`define MFE_CTRL_TRIPLE_EN 2

// Fuse check control field positions
`define MFE_FC_REFRESH 0
`define MFE_FC_ECC 1
`define MFE_FC_CRC 2

// Reset values
`define MFE_RST_STATUS 8'h00
`define MFE_RST_CTRL 8'h00
`define MFE_RST_MASK 8'h00
`define MFE_RST_THR 16'hffff
`define MFE_RST_TIME 8'h00

// Timing
`define MFE_CLK_MHZ 100
`define MFE_TAP_TICK_US 500
`define MFE_SETTLE_US 2500

`endif

// [core/motion_event_pkg.sv]
package motion_event_pkg;

  typedef enum logic [3:0] {
    TAP_IDLE = 4'b0001,
    TAP_PULSE = 4'b0010,
    TAP_GAP = 4'b0100,
    TAP_LOW = 4'b1000
  } tap_state_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] ctrl;
    logic [15:0] or_thr;
    logic [15:0] tap_thr;
    logic [7:0] tap_max_duration;
    logic [7:0] tap_lat;
    logic [7:0] tap_win;
    logic [2:0] fuse_req;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic or_prev;
    logic [15:0] tick_cnt;
    logic tick;
    tap_state_e tap_state;
    logic [9:0] tap_cnt;
    logic [1:0] taps;
    logic irq;
  } state_s;

endpackage

// [core/motion_event_status.sv]
`timescale 1ns/10ps
`default_nettype none
`include "motion_event_defs.svh"

// Function
// RULE1 - Status at 0x12, resets 0x00, read clears
// RULE2 - Bit 7 sets on uncorrectable fuse error
// RULE3 - Fuse flag: sticky OR of three error sources
// RULE4 - User fuse checks; errors raise interrupt
// RULE5 - Inactivity flag set when inactivity detected
// RULE6 - Activity flag set when threshold exceeded
// RULE7 - Overrange sticky holds until one read
// RULE8 - Sticky triggers on level, or edge if selected
// RULE9 - Live overrange follows present acceleration
// RULE10 - Disable bit suppresses both overrange flags
// RULE11 - Single tap: one short over-threshold event
// RULE12 - Double tap needs latency, window above zero
// RULE13 - Second tap after latency+2.5ms, within window
// RULE14 - Triple tap needs enable and three taps
// RULE15 - Third tap after latency+2.5ms, within window
// RULE16 - Event during clearing read is kept
module motion_event_status
  import motion_event_pkg::*;
#(
  parameter int TICK_CYCLES = `MFE_TAP_TICK_US * `MFE_CLK_MHZ
) (
  input wire logic i_mclk,                    // Core clock, 100 MHz
  input wire logic i_arst_n,                  // Async reset, active low
  input wire logic i_hsel,                    // AHB slave select
  input wire logic [31:0] i_haddr,            // AHB address
  input wire logic [1:0] i_htrans,            // AHB transfer type
  input wire logic i_hwrite,                  // AHB write
  input wire logic [2:0] i_hsize,             // AHB size, word only
  input wire logic [31:0] i_hwdata,           // AHB write data
  input wire logic i_hready,                  // AHB bus ready
  output logic o_hreadyout,                   // Slave ready, always high
  output logic [31:0] o_hrdata,               // Read data
  output logic o_hresp,                       // Response, always OKAY
  input wire logic [15:0] i_accel_mag,        // Acceleration magnitude
  input wire logic i_activity_detect,         // Activity function result
  input wire logic i_inactivity_detect,       // Inactivity function result
  input wire logic i_fuse_ctrl_error,         // Fuse controller error
  input wire logic i_fuse_ecc_uncorrectable,  // User ECC check failure
  input wire logic i_fuse_crc_error,          // User CRC check failure
  output logic o_fuse_refresh_start,          // Pulse: start fuse refresh
  output logic o_fuse_ecc_start,              // Pulse: start ECC check
  output logic o_fuse_crc_start,              // Pulse: start CRC check
  output logic o_irq                          // Level interrupt
);

  localparam logic [9:0] SETTLE_TICKS =
    10'((`MFE_SETTLE_US + `MFE_TAP_TICK_US - 1) / `MFE_TAP_TICK_US);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  ////////////////////////////////////////////////////////////////////////////

  logic rst_meta_r;
  logic rst_n_r;

  // Two stages so the release never lands near a clock edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////

  // Word aligned hit inside the small register window
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[31:10] == 22'h0) && (a[1:0] == 2'h0);
  endfunction

  // Widen an eight-bit tick count for gap arithmetic
  function automatic logic [9:0] wide(input logic [7:0] v);
    wide = {2'h0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  state_s s_r;
  state_s s_nxt;
  logic acc;
  logic [7:0] idx;
  logic rd_status;
  logic live;
  logic above;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [9:0] gap_open;
  logic [9:0] gap_close;

  // One process computes the whole next state
  always_comb begin
    s_nxt = s_r;
    acc = i_hsel && i_hready && i_htrans[1] && addr_ok(i_haddr);
    idx = i_haddr[9:2];
    rd_status = acc && !i_hwrite && (idx == `MFE_IDX_STATUS);
    set_v = 8'h00;
    clr_v = 8'h00;
    gap_open = wide(s_r.tap_lat) + SETTLE_TICKS;
    gap_close = gap_open + wide(s_r.tap_win);
    above = i_accel_mag > s_r.tap_thr;

    // Address phase: capture writes, produce read data for the data phase
    s_nxt.fuse_req = 3'h0;
    s_nxt.wr_pend = acc && i_hwrite;
    s_nxt.wr_idx = idx;
    if (acc && !i_hwrite) begin
      unique case (idx)
        `MFE_IDX_STATUS: s_nxt.hrdata = {24'h0, s_r.status}; // see RULE1
        `MFE_IDX_CTRL: s_nxt.hrdata = {24'h0, s_r.ctrl};
        `MFE_IDX_OR_THR: s_nxt.hrdata = {16'h0, s_r.or_thr};
        `MFE_IDX_TAP_THR: s_nxt.hrdata = {16'h0, s_r.tap_thr};
        `MFE_IDX_TAP_MAX_DURATION: s_nxt.hrdata = {24'h0, s_r.tap_max_duration};
        `MFE_IDX_TAP_LAT: s_nxt.hrdata = {24'h0, s_r.tap_lat};
        `MFE_IDX_TAP_WIN: s_nxt.hrdata = {24'h0, s_r.tap_win};
        `MFE_IDX_MASK: s_nxt.hrdata = {24'h0, s_r.mask};
        default: s_nxt.hrdata = 32'h0;
      endcase
    end

    // Data phase: writes land one cycle after their address phase
    if (s_r.wr_pend) begin
      unique case (s_r.wr_idx)
        `MFE_IDX_CTRL: s_nxt.ctrl = {5'h0, i_hwdata[2:0]};
        `MFE_IDX_OR_THR: s_nxt.or_thr = i_hwdata[15:0];
        `MFE_IDX_TAP_THR: s_nxt.tap_thr = i_hwdata[15:0];
        `MFE_IDX_TAP_MAX_DURATION: s_nxt.tap_max_duration = i_hwdata[7:0];
        `MFE_IDX_TAP_LAT: s_nxt.tap_lat = i_hwdata[7:0];
        `MFE_IDX_TAP_WIN: s_nxt.tap_win = i_hwdata[7:0];
        `MFE_IDX_MASK: s_nxt.mask = i_hwdata[7:0];
        `MFE_IDX_FUSE_CHK: s_nxt.fuse_req = i_hwdata[2:0]; // see RULE4
        default: s_nxt.fuse_req = 3'h0;
      endcase
    end

    // Tap time base; a tick every TICK_CYCLES keeps tap counters narrow
    s_nxt.tick = 1'b0;
    s_nxt.tick_cnt = s_r.tick_cnt + 16'h1;
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = 16'h0;
      s_nxt.tick = 1'b1;
    end

    // Overrange: live level, then level or rising-edge trigger for the sticky
    live = !s_r.ctrl[`MFE_CTRL_OR_DIS] && (i_accel_mag > s_r.or_thr); // see RULE9 see RULE10
    s_nxt.or_prev = live;
    set_v[`MFE_ST_OR_STICKY] = live && (!s_r.ctrl[`MFE_CTRL_TRIG_SEL] || !s_r.or_prev); // see RULE7 see RULE8

    // Fuse error accumulation from all three checkers
    set_v[`MFE_ST_FUSE] = i_fuse_ctrl_error || i_fuse_ecc_uncorrectable || i_fuse_crc_error; // see RULE2 see RULE3
    set_v[`MFE_ST_INACTIVITY_FLAG] = i_inactivity_detect; // see RULE5
    set_v[`MFE_ST_ACT] = i_activity_detect; // see RULE6

    // Tap sequencer; a tap counts only if it falls below threshold in time
    unique case (s_r.tap_state)
      TAP_IDLE: begin
        if (above) begin
          s_nxt.tap_state = TAP_PULSE;
          s_nxt.tap_cnt = 10'h0;
          s_nxt.taps = 2'h0;
        end
      end
      TAP_PULSE: begin
        if (!above) begin
          s_nxt.tap_state = TAP_IDLE;
          s_nxt.tap_cnt = 10'h0;
          unique case (s_r.taps)
            2'h0: begin
              set_v[`MFE_ST_SINGLE] = 1'b1; // see RULE11
              if (s_r.tap_lat != 8'h0 && s_r.tap_win != 8'h0) begin // see RULE12
                s_nxt.tap_state = TAP_GAP;
                s_nxt.taps = 2'h1;
              end
            end
            2'h1: begin
              // Times rewritten mid-sequence must not yield a double
              set_v[`MFE_ST_DOUBLE] = (s_r.tap_lat != 8'h0) && (s_r.tap_win != 8'h0); // see RULE12
              if (s_r.ctrl[`MFE_CTRL_TRIPLE_EN]) begin // see RULE14
                s_nxt.tap_state = TAP_GAP;
                s_nxt.taps = 2'h2;
              end
            end
            default: set_v[`MFE_ST_TRIPLE] = s_r.ctrl[`MFE_CTRL_TRIPLE_EN]; // see RULE14
          endcase
        end else if (s_r.tap_cnt >= wide(s_r.tap_max_duration)) begin
          s_nxt.tap_state = TAP_LOW; // Too long: not a tap
        end else if (s_r.tick) begin
          s_nxt.tap_cnt = s_r.tap_cnt + 10'h1;
        end
      end
      TAP_GAP: begin
        if (above) begin
          // Early or late taps abort the sequence
          if (s_r.tap_cnt >= gap_open && s_r.tap_cnt < gap_close) begin // see RULE13 see RULE15
            s_nxt.tap_state = TAP_PULSE;
            s_nxt.tap_cnt = 10'h0;
          end else begin
            s_nxt.tap_state = TAP_LOW;
          end
        end else if (s_r.tap_cnt >= gap_close) begin
          s_nxt.tap_state = TAP_IDLE;
        end else if (s_r.tick) begin
          s_nxt.tap_cnt = s_r.tap_cnt + 10'h1;
        end
      end
      TAP_LOW: begin
        if (!above) begin
          s_nxt.tap_state = TAP_IDLE;
        end
      end
    endcase

    // Read clears every sticky bit; a set in the same cycle wins
    if (rd_status) begin
      clr_v = 8'hff;
    end
    s_nxt.status = (s_r.status & ~clr_v) | set_v; // see RULE1 see RULE16
    s_nxt.status[`MFE_ST_OR_LIVE] = live; // see RULE9
    s_nxt.irq = |(s_nxt.status & s_nxt.mask); // see RULE4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
      s_r.status <= `MFE_RST_STATUS;
      s_r.mask <= `MFE_RST_MASK;
      s_r.ctrl <= `MFE_RST_CTRL;
      s_r.or_thr <= `MFE_RST_THR;
      s_r.tap_thr <= `MFE_RST_THR;
      s_r.tap_max_duration <= `MFE_RST_TIME;
      s_r.tap_lat <= `MFE_RST_TIME;
      s_r.tap_win <= `MFE_RST_TIME;
      s_r.tap_state <= TAP_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait states: every access completes in one data phase
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = s_r.hrdata;
  assign o_fuse_refresh_start = s_r.fuse_req[`MFE_FC_REFRESH];
  assign o_fuse_ecc_start = s_r.fuse_req[`MFE_FC_ECC];
  assign o_fuse_crc_start = s_r.fuse_req[`MFE_FC_CRC];
  assign o_irq = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n_r);

  sequence s_status_read;
    rd_status;
  endsequence

  sequence s_fuse_event;
    i_fuse_ctrl_error || i_fuse_ecc_uncorrectable || i_fuse_crc_error;
  endsequence

  property p_read_returns_and_clears;
    s_status_read ##0 !set_v[`MFE_ST_ACT] |=> (o_hrdata[7:0] == $past(s_r.status)) && !s_r.status[`MFE_ST_ACT];
  endproperty
  a_read_returns_and_clears: assert property (p_read_returns_and_clears) else $error("status read wrong"); // see RULE1

  property p_fuse_sets;
    s_fuse_event |=> s_r.status[`MFE_ST_FUSE] ##1 (s_r.status[`MFE_ST_FUSE] || $past(rd_status));
  endproperty
  a_fuse_sets: assert property (p_fuse_sets) else $error("fuse flag missing"); // see RULE3

  property p_set_wins;
    s_status_read and s_fuse_event |=> s_r.status[`MFE_ST_FUSE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost at read"); // see RULE16

  property p_activity;
    i_activity_detect |=> s_r.status[`MFE_ST_ACT];
  endproperty
  a_activity: assert property (p_activity) else $error("activity flag missing"); // see RULE6

  property p_inactivity;
    i_inactivity_detect |=> s_r.status[`MFE_ST_INACTIVITY_FLAG];
  endproperty
  a_inactivity: assert property (p_inactivity) else $error("inactivity flag missing"); // see RULE5

  property p_live_follows;
    s_r.status[`MFE_ST_OR_LIVE] == $past(!s_r.ctrl[`MFE_CTRL_OR_DIS] && (i_accel_mag > s_r.or_thr));
  endproperty
  a_live_follows: assert property (p_live_follows) else $error("live overrange wrong"); // see RULE9

  property p_disable;
    s_r.ctrl[`MFE_CTRL_OR_DIS] ##0 s_status_read |=>
      !s_r.status[`MFE_ST_OR_LIVE] && !s_r.status[`MFE_ST_OR_STICKY];
  endproperty
  a_disable: assert property (p_disable) else $error("overrange not suppressed"); // see RULE10

  property p_sticky_holds;
    s_r.status[`MFE_ST_OR_STICKY] && !rd_status |=> s_r.status[`MFE_ST_OR_STICKY];
  endproperty
  a_sticky_holds: assert property (p_sticky_holds) else $error("sticky overrange dropped"); // see RULE7

  property p_level_trigger;
    s_status_read ##0 (!s_r.ctrl[`MFE_CTRL_TRIG_SEL] && live) |=> s_r.status[`MFE_ST_OR_STICKY];
  endproperty
  a_level_trigger: assert property (p_level_trigger) else $error("level trigger failed"); // see RULE8

  property p_double_needs_times;
    set_v[`MFE_ST_DOUBLE] |-> (s_r.tap_lat != 8'h0) && (s_r.tap_win != 8'h0);
  endproperty
  a_double_needs_times: assert property (p_double_needs_times) else $error("double tap without times"); // see RULE12

  property p_triple_needs_enable;
    set_v[`MFE_ST_TRIPLE] |-> s_r.ctrl[`MFE_CTRL_TRIPLE_EN] ##1 s_r.status[`MFE_ST_TRIPLE];
  endproperty
  a_triple_needs_enable: assert property (p_triple_needs_enable) else $error("triple tap without enable"); // see RULE14

  property p_irq_gate;
    o_irq == |(s_r.status & s_r.mask);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong"); // see RULE4

endmodule

`default_nettype wire

// [verification/motion_event_status_register_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "motion_event_defs.svh"

module motion_event_status_register_tb_top;
  localparam int TK = 10; // Short tap tick keeps tap runs brief
  logic i_mclk;
  logic i_arst_n;
  logic i_hsel;
  logic [31:0] i_haddr;
  logic [1:0] i_htrans;
  logic i_hwrite;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata;
  wire logic i_hready;
  logic o_hreadyout;
  logic [31:0] o_hrdata;
  logic o_hresp;
  logic [15:0] i_accel_mag;
  logic [4:0] ev_drv; // Fuse ctrl, ecc, crc, activity, inactivity
  logic [4:0] side_ev;
  logic o_fuse_refresh_start;
  logic o_fuse_ecc_start;
  logic o_fuse_crc_start;
  logic o_irq;
  logic [31:0] rdat;
  int n_mismatch;
  int num_checks;
  logic [7:0] ridx [9] = '{`MFE_IDX_STATUS, `MFE_IDX_CTRL, `MFE_IDX_OR_THR, `MFE_IDX_TAP_THR,
    `MFE_IDX_TAP_MAX_DURATION, `MFE_IDX_TAP_LAT, `MFE_IDX_TAP_WIN, `MFE_IDX_MASK, `MFE_IDX_FUSE_CHK};
  logic [31:0] rrst [9] = '{32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  int gaps [2] = '{3, 16};

  // The single slave drives the bus ready
  assign i_hready = o_hreadyout;

  motion_event_status #(.TICK_CYCLES(TK)) dut_u (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_accel_mag(i_accel_mag),
    .i_activity_detect(ev_drv[3]), .i_inactivity_detect(ev_drv[4]), .i_fuse_ctrl_error(ev_drv[0]),
    .i_fuse_ecc_uncorrectable(ev_drv[1]), .i_fuse_crc_error(ev_drv[2]),
    .o_fuse_refresh_start(o_fuse_refresh_start), .o_fuse_ecc_start(o_fuse_ecc_start),
    .o_fuse_crc_start(o_fuse_crc_start), .o_irq(o_irq));

  // 100 MHz core clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bounded wait for ready; a stuck bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (i_hready !== 1'b1 && n < 16);
    if (i_hready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask

  // One AHB single transfer; side_ev lets an event hit the edge that takes the address
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {22'h0, idx, 2'h0};
    i_hwrite <= wr;
    ev_drv <= ev_drv | side_ev;
    wait_rdy();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    ev_drv <= ev_drv & ~side_ev;
    side_ev = 5'h0;
    wait_rdy();
    rd = o_hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rdat);
    chk(nm, rdat & msk, exp);
  endtask

  task automatic pulse(input logic [4:0] m);
    @(posedge i_mclk);
    ev_drv <= m;
    @(posedge i_mclk);
    ev_drv <= 5'h0;
    repeat (2) @(posedge i_mclk);
  endtask

  // Over-threshold pulse of hi ticks, then quiet for gap ticks
  task automatic tap(input int hi, input int gap);
    @(posedge i_mclk);
    i_accel_mag <= 16'h0200;
    repeat (hi * TK) @(posedge i_mclk);
    i_accel_mag <= 16'h0000;
    repeat (gap * TK) @(posedge i_mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    i_accel_mag = 16'h0;
    ev_drv = 5'h0;
    side_ev = 5'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    // Reset values, unmapped place and read-only status
    for (int k = 0; k < 9; k++) begin
      rdc("reset value", ridx[k], 32'hffffffff, rrst[k]);
    end
    chk("response okay", {31'h0, o_hresp}, 32'h0);
    chk("ready high", {31'h0, o_hreadyout}, 32'h1);
    wr(8'h3f, 32'hffffffff);
    rdc("unmapped", 8'h3f, 32'hffffffff, 32'h0);
    wr(`MFE_IDX_STATUS, 32'hff);
    rdc("status after write", `MFE_IDX_STATUS, 32'hffffffff, 32'h0);
    // Each fuse error source sets the sticky flag; each check start pulses once
    for (int k = 0; k < 3; k++) begin
      pulse(5'h1 << k);
      rdc("fuse flag set", `MFE_IDX_STATUS, 32'h80, 32'h80);
      rdc("fuse flag cleared", `MFE_IDX_STATUS, 32'h80, 32'h0);
      wr(`MFE_IDX_FUSE_CHK, 32'h1 << k);
      #1;
      chk("fuse start", {29'h0, o_fuse_crc_start, o_fuse_ecc_start, o_fuse_refresh_start}, 32'h1 << k);
      @(posedge i_mclk);
      #1;
      chk("fuse start end", {29'h0, o_fuse_crc_start, o_fuse_ecc_start, o_fuse_refresh_start}, 32'h0);
    end
    pulse(5'h08);
    rdc("activity", `MFE_IDX_STATUS, 32'h60, 32'h20);
    pulse(5'h10);
    rdc("inactivity", `MFE_IDX_STATUS, 32'h60, 32'h40);
    // Event on the very edge of the clearing read must survive
    side_ev = 5'h09;
    rdc("read with same cycle event", `MFE_IDX_STATUS, 32'ha0, 32'h0);
    rdc("event kept across clear", `MFE_IDX_STATUS, 32'ha0, 32'ha0);
    // Interrupt: masked event stays quiet, unmasked one raises, read drops it
    wr(`MFE_IDX_MASK, 32'h20);
    pulse(5'h10);
    chk("irq masked", {31'h0, o_irq}, 32'h0);
    pulse(5'h08);
    chk("irq raised", {31'h0, o_irq}, 32'h1);
    rdc("clear for irq", `MFE_IDX_STATUS, 32'h60, 32'h60);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("irq dropped", {31'h0, o_irq}, 32'h0);
    // Overrange: level trigger, edge trigger, then disabled
    wr(`MFE_IDX_OR_THR, 32'h100);
    i_accel_mag <= 16'h0200;
    repeat (3) @(posedge i_mclk);
    rdc("overrange level", `MFE_IDX_STATUS, 32'h18, 32'h18);
    rdc("sticky re-set by level", `MFE_IDX_STATUS, 32'h18, 32'h18);
    i_accel_mag <= 16'h0;
    repeat (3) @(posedge i_mclk);
    rdc("sticky holds", `MFE_IDX_STATUS, 32'h18, 32'h10);
    rdc("sticky cleared", `MFE_IDX_STATUS, 32'h18, 32'h0);
    wr(`MFE_IDX_CTRL, 32'h2);
    i_accel_mag <= 16'h0200;
    repeat (3) @(posedge i_mclk);
    rdc("edge trigger", `MFE_IDX_STATUS, 32'h18, 32'h18);
    rdc("edge no re-set", `MFE_IDX_STATUS, 32'h18, 32'h08);
    i_accel_mag <= 16'h0;
    wr(`MFE_IDX_CTRL, 32'h1);
    i_accel_mag <= 16'h0200;
    repeat (3) @(posedge i_mclk);
    rdc("overrange disabled", `MFE_IDX_STATUS, 32'h18, 32'h0);
    i_accel_mag <= 16'h0;
    // Taps: duration 4, latency 2, window 6 ticks; second tap legal at gap 7..12
    wr(`MFE_IDX_CTRL, 32'h0);
    wr(`MFE_IDX_TAP_THR, 32'h100);
    wr(`MFE_IDX_TAP_MAX_DURATION, 32'h4);
    wr(`MFE_IDX_TAP_LAT, 32'h2);
    wr(`MFE_IDX_TAP_WIN, 32'h6);
    bus(1'b0, `MFE_IDX_STATUS, 32'h0, rdat);
    tap(2, 30);
    rdc("single tap", `MFE_IDX_STATUS, 32'h07, 32'h01);
    tap(8, 30);
    rdc("long pulse", `MFE_IDX_STATUS, 32'h07, 32'h00);
    tap(2, 8);
    tap(2, 30);
    rdc("double tap", `MFE_IDX_STATUS, 32'h07, 32'h03);
    for (int k = 0; k < 2; k++) begin
      tap(2, gaps[k]);
      tap(2, 30);
      rdc("mistimed second tap", `MFE_IDX_STATUS, 32'h02, 32'h0);
    end
    wr(`MFE_IDX_TAP_LAT, 32'h0);
    tap(2, 8);
    tap(2, 30);
    rdc("double at zero latency", `MFE_IDX_STATUS, 32'h02, 32'h0);
    wr(`MFE_IDX_TAP_LAT, 32'h2);
    for (int k = 0; k < 2; k++) begin
      wr(`MFE_IDX_CTRL, k == 0 ? 32'h4 : 32'h0);
      tap(2, 8);
      tap(2, 8);
      tap(2, 30);
      rdc("triple tap", `MFE_IDX_STATUS, 32'h04, k == 0 ? 32'h04 : 32'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
